/* shared/spdenc_pkg.sv */
// Constants for the speed and direction pulse encoder
`default_nettype none
package spdenc_pkg;
  localparam int CLK_HZ = 10_000_000;
  localparam int CYC_PER_US = CLK_HZ / 1_000_000;
  // Factory width option codes
  localparam logic [1:0] OPT_INTER  = 2'h0;
  localparam logic [1:0] OPT_NARROW = 2'h1;
  localparam logic [1:0] OPT_WIDE   = 2'h2;
  // Direction codes shown on the status port
  localparam logic [1:0] DIRC_FWD = 2'h0;
  localparam logic [1:0] DIRC_REV = 2'h1;
  localparam logic [1:0] DIRC_UNK = 2'h2;
  // Nominal pulse widths in microseconds
  localparam int INTER_FWD_US  = 60;
  localparam int INTER_REV_US  = 120;
  localparam int INTER_UNK_US  = 30;
  localparam int HS_US         = 30;
  localparam int NARROW_FWD_US = 45;
  localparam int NARROW_REV_US = 90;
  localparam int NARROW_UNK_US = 180;
  localparam int WIDE_FWD_US   = 45;
  localparam int WIDE_REV_US   = 180;
  localparam int WIDE_UNK_US   = 360;
  localparam int WW = 12;
  localparam logic [WW-1:0] INTER_FWD_CYC  = WW'(INTER_FWD_US * CYC_PER_US);
  localparam logic [WW-1:0] INTER_REV_CYC  = WW'(INTER_REV_US * CYC_PER_US);
  localparam logic [WW-1:0] INTER_UNK_CYC  = WW'(INTER_UNK_US * CYC_PER_US);
  localparam logic [WW-1:0] HS_CYC         = WW'(HS_US * CYC_PER_US);
  localparam logic [WW-1:0] NARROW_FWD_CYC = WW'(NARROW_FWD_US * CYC_PER_US);
  localparam logic [WW-1:0] NARROW_REV_CYC = WW'(NARROW_REV_US * CYC_PER_US);
  localparam logic [WW-1:0] NARROW_UNK_CYC = WW'(NARROW_UNK_US * CYC_PER_US);
  localparam logic [WW-1:0] WIDE_FWD_CYC   = WW'(WIDE_FWD_US * CYC_PER_US);
  localparam logic [WW-1:0] WIDE_REV_CYC   = WW'(WIDE_REV_US * CYC_PER_US);
  localparam logic [WW-1:0] WIDE_UNK_CYC   = WW'(WIDE_UNK_US * CYC_PER_US);
  // High-speed hysteresis, nominal frequencies in Hz
  localparam int HS_ENTER_HZ = 1100;
  localparam int HS_EXIT_HZ  = 1000;
  localparam int PW = 24;
  localparam int HS_ENTER_CYC = CLK_HZ / HS_ENTER_HZ;
  localparam int HS_EXIT_CYC  = CLK_HZ / HS_EXIT_HZ;
  localparam int TIMEOUT_MS   = 100;
  localparam int TIMEOUT_CYC  = (CLK_HZ / 1000) * TIMEOUT_MS;
  // Switch points in percent of peak-to-peak
  localparam logic [6:0] OPERATE_PCT = 7'h4b;
  localparam logic [6:0] RELEASE_PCT = 7'h19;
  localparam logic [2:0] CAL_CYCLES  = 3'h4;
  localparam int SW = 12;
endpackage
`default_nettype wire

/* rtl/spdenc_top.sv */
// Speed and direction pulse encoder with switch points and width selection
// Functional notes
// - Enter high-speed above entry frequency
// - Leave high-speed below lower exit frequency
// - Intermediate: 60/120/30 us forward/reverse/unknown
// - High-speed: all pulses 30 us, no direction
// - Narrow: 45/90/180 us forward/reverse/unknown
// - Wide: 45/180/360 us forward/reverse/unknown
// - Pulse rate limited by resolvable low gap
// - Faster receivers may exceed reverse/unknown rates
// - Timed reset variant forgets calibration
// - Switch at 75 and 25 percent points
// - At most one pulse per target cycle; a target cycle that starts during a pulse is dropped
// - Supply-to-ground motion is forward, swappable
// - Width timed from start of rising edge
`default_nettype none
module spdenc_top #(
  parameter logic [spdenc_pkg::PW-1:0] HS_ENTER_PERIOD = spdenc_pkg::PW'(spdenc_pkg::HS_ENTER_CYC),
  parameter logic [spdenc_pkg::PW-1:0] HS_EXIT_PERIOD  = spdenc_pkg::PW'(spdenc_pkg::HS_EXIT_CYC),
  parameter logic [spdenc_pkg::PW-1:0] TIMEOUT_PERIOD  = spdenc_pkg::PW'(spdenc_pkg::TIMEOUT_CYC)
) (
  input  wire logic                         ref_clk,
  input  wire logic                         rst_n,
  input  wire logic [1:0]                   width_option,
  input  wire logic                         reversed_orientation,
  input  wire logic                         timed_reset_enable,
  input  wire logic signed [spdenc_pkg::SW-1:0] chan_a_sample,
  input  wire logic signed [spdenc_pkg::SW-1:0] chan_b_sample,
  output logic                              current_high_ff,
  output logic                              high_speed_ff,
  output logic [1:0]                        direction_code_ff,
  output logic                              calibrated_ff
);
  typedef enum logic {SPDENC_IDLE, SPDENC_HIGH} spdenc_state_e;

  function automatic logic signed [spdenc_pkg::SW-1:0] spdenc_thr(
    input logic signed [spdenc_pkg::SW-1:0] mx,
    input logic signed [spdenc_pkg::SW-1:0] mn,
    input logic [6:0]                       pct);
    logic signed [21:0] span;
    span = (22'(mx) - 22'(mn)) * $signed({15'h0, pct});
    return spdenc_pkg::SW'(22'(mn) + span / 22'sh64);
  endfunction

  function automatic logic [spdenc_pkg::WW-1:0] spdenc_width(
    input logic [1:0] opt,
    input logic       hs,
    input logic [1:0] dirc);
    logic [spdenc_pkg::WW-1:0] w;
    w = spdenc_pkg::INTER_UNK_CYC;
    case (opt)
      spdenc_pkg::OPT_NARROW: begin
        w = (dirc == spdenc_pkg::DIRC_FWD) ? spdenc_pkg::NARROW_FWD_CYC :
            (dirc == spdenc_pkg::DIRC_REV) ? spdenc_pkg::NARROW_REV_CYC :
            spdenc_pkg::NARROW_UNK_CYC;
      end
      spdenc_pkg::OPT_WIDE: begin
        w = (dirc == spdenc_pkg::DIRC_FWD) ? spdenc_pkg::WIDE_FWD_CYC :
            (dirc == spdenc_pkg::DIRC_REV) ? spdenc_pkg::WIDE_REV_CYC :
            spdenc_pkg::WIDE_UNK_CYC;
      end
      default: begin
        if (hs) begin
          w = spdenc_pkg::HS_CYC;
        end else begin
          w = (dirc == spdenc_pkg::DIRC_FWD) ? spdenc_pkg::INTER_FWD_CYC :
              (dirc == spdenc_pkg::DIRC_REV) ? spdenc_pkg::INTER_REV_CYC :
              spdenc_pkg::INTER_UNK_CYC;
        end
      end
    endcase
    return w;
  endfunction

  logic signed [spdenc_pkg::SW-1:0] smp [2];
  logic signed [spdenc_pkg::SW-1:0] op_ff [2];
  logic [1:0]                       sw_ff;
  logic [1:0]                       sw_d_ff;
  logic [1:0]                       evt;
  logic [spdenc_pkg::PW-1:0]        per_cnt_ff;
  logic [2:0]                       seen_ff;
  logic                             last_fwd_ff;
  logic                             cur_fwd;
  logic [1:0]                       nxt_dirc;
  logic [spdenc_pkg::WW-1:0]        cnt_ff;
  logic [spdenc_pkg::WW-1:0]        width_ff;
  logic                             timeout;
  spdenc_state_e                    state_ff;

  assign smp[0] = chan_a_sample;
  assign smp[1] = chan_b_sample;

  // Per-channel peak tracking and hysteretic switching
  for (genvar ch = 0; ch < 2; ch++) begin : g_chan
    logic signed [spdenc_pkg::SW-1:0] max_ff;
    logic signed [spdenc_pkg::SW-1:0] min_ff;
    logic signed [spdenc_pkg::SW-1:0] rp_ff;
    assign evt[ch] = sw_ff[ch] & ~sw_d_ff[ch];
    always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
        max_ff    <= '0;
        min_ff    <= '0;
        op_ff[ch] <= '0;
        rp_ff     <= '0;
      end else if (evt[ch]) begin
        op_ff[ch] <= spdenc_thr(max_ff, min_ff, spdenc_pkg::OPERATE_PCT);
        rp_ff     <= spdenc_thr(max_ff, min_ff, spdenc_pkg::RELEASE_PCT);
        max_ff    <= smp[ch];
        min_ff    <= smp[ch];
      end else begin
        if (smp[ch] > max_ff) max_ff <= smp[ch];
        if (smp[ch] < min_ff) min_ff <= smp[ch];
      end
    end
    always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
        sw_ff[ch]   <= 1'b0;
        sw_d_ff[ch] <= 1'b0;
      end else begin
        sw_d_ff[ch] <= sw_ff[ch];
        if (!sw_ff[ch] && smp[ch] > op_ff[ch]) sw_ff[ch] <= 1'b1;
        else if (sw_ff[ch] && smp[ch] < rp_ff) sw_ff[ch] <= 1'b0;
      end
    end
  end

  // Target-cycle period; timeout only in the timed-reset variant
  assign timeout = timed_reset_enable && (per_cnt_ff == TIMEOUT_PERIOD);
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      per_cnt_ff <= '1;
    end else if (evt[0]) begin
      per_cnt_ff <= '0;
    end else if (per_cnt_ff != '1) begin
      per_cnt_ff <= per_cnt_ff + 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      high_speed_ff <= 1'b0;
    end else if (width_option != spdenc_pkg::OPT_INTER || timeout) begin
      high_speed_ff <= 1'b0;
    end else if (evt[0] && per_cnt_ff < HS_ENTER_PERIOD) begin
      high_speed_ff <= 1'b1;
    end else if (evt[0] && per_cnt_ff > HS_EXIT_PERIOD) begin
      high_speed_ff <= 1'b0;
    end
  end

  // Channel B state at channel A operate edge gives the sense
  assign cur_fwd = sw_ff[1] ^ reversed_orientation;
  assign nxt_dirc = (seen_ff != spdenc_pkg::CAL_CYCLES || cur_fwd != last_fwd_ff) ?
                    spdenc_pkg::DIRC_UNK :
                    (cur_fwd ? spdenc_pkg::DIRC_FWD : spdenc_pkg::DIRC_REV);

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      seen_ff     <= '0;
      last_fwd_ff <= 1'b0;
    end else if (timeout) begin
      seen_ff <= '0;
    end else if (evt[0]) begin
      last_fwd_ff <= cur_fwd;
      if (seen_ff != spdenc_pkg::CAL_CYCLES) seen_ff <= seen_ff + 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      calibrated_ff <= 1'b0;
    end else begin
      calibrated_ff <= (seen_ff == spdenc_pkg::CAL_CYCLES);
    end
  end

  // One pulse per target cycle; an event during a pulse is dropped
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff          <= SPDENC_IDLE;
      cnt_ff            <= '0;
      width_ff          <= '0;
      current_high_ff   <= 1'b0;
      direction_code_ff <= spdenc_pkg::DIRC_UNK;
    end else begin
      case (state_ff)
        SPDENC_IDLE: begin
          if (evt[0]) begin
            state_ff          <= SPDENC_HIGH;
            width_ff          <= spdenc_width(width_option, high_speed_ff, nxt_dirc);
            cnt_ff            <= spdenc_width(width_option, high_speed_ff, nxt_dirc) - 1'b1;
            current_high_ff   <= 1'b1;
            direction_code_ff <= high_speed_ff ? spdenc_pkg::DIRC_UNK : nxt_dirc;
          end
        end
        SPDENC_HIGH: begin
          if (cnt_ff == '0) begin
            // Next event is taken at once; no enforced low gap
            state_ff        <= SPDENC_IDLE;
            current_high_ff <= 1'b0;
          end else begin
            cnt_ff <= cnt_ff - 1'b1;
          end
        end
        default: begin
          state_ff        <= SPDENC_IDLE;
          current_high_ff <= 1'b0;
        end
      endcase
    end
  end

  // Checking helpers
  logic [spdenc_pkg::WW-1:0] hi_len_ff;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) hi_len_ff <= '0;
    else if (current_high_ff) hi_len_ff <= hi_len_ff + 1'b1;
    else hi_len_ff <= '0;
  end

  a_pulse_len_exact: assert property (@(posedge ref_clk) disable iff (!rst_n)
    $fell(current_high_ff) |-> hi_len_ff == width_ff)
    else $error("pulse length differs from selected width");
  a_hs_width_only: assert property (@(posedge ref_clk) disable iff (!rst_n)
    $rose(current_high_ff) && $past(high_speed_ff) |->
      width_ff == spdenc_pkg::HS_CYC && direction_code_ff == spdenc_pkg::DIRC_UNK)
    else $error("high-speed pulse not 30 us");
  a_hs_inter_only: assert property (@(posedge ref_clk) disable iff (!rst_n)
    high_speed_ff |-> $past(width_option) == spdenc_pkg::OPT_INTER)
    else $error("high-speed outside intermediate option");
  a_hs_entry: assert property (@(posedge ref_clk) disable iff (!rst_n)
    evt[0] && per_cnt_ff < HS_ENTER_PERIOD && width_option == spdenc_pkg::OPT_INTER
      && !timeout |=> high_speed_ff)
    else $error("high-speed not entered");
  a_hs_hold_gap: assert property (@(posedge ref_clk) disable iff (!rst_n)
    high_speed_ff && evt[0] && per_cnt_ff <= HS_EXIT_PERIOD
      && width_option == spdenc_pkg::OPT_INTER && !timeout |=> high_speed_ff)
    else $error("high-speed left inside hysteresis band");
  a_hs_exit: assert property (@(posedge ref_clk) disable iff (!rst_n)
    evt[0] && per_cnt_ff > HS_EXIT_PERIOD |=> !high_speed_ff)
    else $error("high-speed not left");
  a_inter_fwd_w: assert property (@(posedge ref_clk) disable iff (!rst_n)
    $rose(current_high_ff) && $past(width_option) == spdenc_pkg::OPT_INTER
      && direction_code_ff == spdenc_pkg::DIRC_FWD |-> width_ff == spdenc_pkg::INTER_FWD_CYC)
    else $error("intermediate forward width wrong");
  a_narrow_rev_w: assert property (@(posedge ref_clk) disable iff (!rst_n)
    $rose(current_high_ff) && $past(width_option) == spdenc_pkg::OPT_NARROW
      && direction_code_ff == spdenc_pkg::DIRC_REV |-> width_ff == spdenc_pkg::NARROW_REV_CYC)
    else $error("narrow reverse width wrong");
  a_wide_unk_w: assert property (@(posedge ref_clk) disable iff (!rst_n)
    $rose(current_high_ff) && $past(width_option) == spdenc_pkg::OPT_WIDE
      && direction_code_ff == spdenc_pkg::DIRC_UNK |-> width_ff == spdenc_pkg::WIDE_UNK_CYC)
    else $error("wide unknown width wrong");
  a_one_pulse: assert property (@(posedge ref_clk) disable iff (!rst_n)
    evt[0] && state_ff == SPDENC_IDLE |=> $rose(current_high_ff) ##1 current_high_ff)
    else $error("target cycle produced no pulse");
  a_timeout_clear: assert property (@(posedge ref_clk) disable iff (!rst_n)
    timeout |=> seen_ff == '0 ##1 !calibrated_ff)
    else $error("timed reset did not clear calibration");
  a_operate_sw: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !sw_ff[0] && smp[0] > op_ff[0] |=> sw_ff[0])
    else $error("operate point crossing missed");

  c_fwd_pulse: cover property (@(posedge ref_clk) disable iff (!rst_n)
    $rose(current_high_ff) && direction_code_ff == spdenc_pkg::DIRC_FWD);
  c_rev_pulse: cover property (@(posedge ref_clk) disable iff (!rst_n)
    $rose(current_high_ff) && direction_code_ff == spdenc_pkg::DIRC_REV);
  c_hs_enter: cover property (@(posedge ref_clk) disable iff (!rst_n) $rose(high_speed_ff));
  c_timeout: cover property (@(posedge ref_clk) disable iff (!rst_n) timeout);
endmodule
`default_nettype wire

/* tb/spdenc_rx.sv */
// Receiver model that times and classifies output current pulses
`default_nettype none
module spdenc_rx (
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  input  wire logic        current_high,
  input  wire logic [1:0]  width_option,
  output logic      [15:0] width_ff,
  output logic      [15:0] count_ff,
  output logic      [1:0]  class_ff
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] run_ff;
  // Window of 15 percent either side of a nominal width
  function automatic logic near(input logic [15:0] w, input int us);
    return int'(w) * 100 >= us * spdenc_pkg::CYC_PER_US * 85
        && int'(w) * 100 <= us * spdenc_pkg::CYC_PER_US * 115;
  endfunction
  function automatic logic [1:0] classify(input logic [15:0] w, input logic [1:0] opt);
    int f;
    int r;
    int u;
    f = spdenc_pkg::INTER_FWD_US;
    r = spdenc_pkg::INTER_REV_US;
    u = spdenc_pkg::INTER_UNK_US;
    if (opt == spdenc_pkg::OPT_NARROW) begin
      f = spdenc_pkg::NARROW_FWD_US;
      r = spdenc_pkg::NARROW_REV_US;
      u = spdenc_pkg::NARROW_UNK_US;
    end else if (opt == spdenc_pkg::OPT_WIDE) begin
      f = spdenc_pkg::WIDE_FWD_US;
      r = spdenc_pkg::WIDE_REV_US;
      u = spdenc_pkg::WIDE_UNK_US;
    end
    if (near(w, f)) return spdenc_pkg::DIRC_FWD;
    if (near(w, r)) return spdenc_pkg::DIRC_REV;
    if (near(w, u)) return spdenc_pkg::DIRC_UNK;
    return 2'h3;
  endfunction
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      run_ff <= '0;
      width_ff <= '0;
      count_ff <= '0;
      class_ff <= 2'h3;
    end else if (current_high) begin
      run_ff <= run_ff + 16'h1;
      if (run_ff == 16'h0) count_ff <= count_ff + 16'h1;
    end else if (run_ff != 16'h0) begin
      width_ff <= run_ff;
      class_ff <= classify(run_ff, width_option);
      run_ff <= '0;
    end
  end
endmodule
`default_nettype wire

/* tb/tb.sv */
// Self-checking bench for the speed and direction pulse encoder
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int LIMIT_CYC = 98000;
  localparam int TMO_CYC   = 8000;
  localparam logic [1:0] F = spdenc_pkg::DIRC_FWD;
  localparam logic [1:0] R = spdenc_pkg::DIRC_REV;
  localparam logic [1:0] U = spdenc_pkg::DIRC_UNK;
  logic                             ref_clk;
  logic                             rst_n;
  logic [1:0]                       width_option;
  logic                             reversed_orientation;
  logic                             timed_reset_enable;
  logic signed [spdenc_pkg::SW-1:0] chan_a_sample;
  logic signed [spdenc_pkg::SW-1:0] chan_b_sample;
  logic                             current_high_ff;
  logic                             high_speed_ff;
  logic [1:0]                       direction_code_ff;
  logic                             calibrated_ff;
  logic [15:0]                      width_ff;
  logic [15:0]                      count_ff;
  logic [1:0]                       class_ff;
  int                               failures;
  int                               num_checks;
  int                               cycles;
  spdenc_top #(
    .HS_ENTER_PERIOD (spdenc_pkg::PW'(2000)),
    .HS_EXIT_PERIOD  (spdenc_pkg::PW'(2400)),
    .TIMEOUT_PERIOD  (spdenc_pkg::PW'(TMO_CYC))
  ) dut_u (
    .ref_clk(ref_clk), .rst_n(rst_n), .width_option(width_option),
    .reversed_orientation(reversed_orientation), .timed_reset_enable(timed_reset_enable),
    .chan_a_sample(chan_a_sample), .chan_b_sample(chan_b_sample),
    .current_high_ff(current_high_ff), .high_speed_ff(high_speed_ff),
    .direction_code_ff(direction_code_ff), .calibrated_ff(calibrated_ff));
  spdenc_rx rx_u (.ref_clk(ref_clk), .rst_n(rst_n), .current_high(current_high_ff),
    .width_option(width_option), .width_ff(width_ff), .count_ff(count_ff),
    .class_ff(class_ff));
  always #50 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == LIMIT_CYC) begin
      failures++;
      print_verdict();
    end
  end
  task automatic print_verdict();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("BAD %0t got %0h expected %0h", $time, got, exp);
    end
  endtask
  // Holds both channel samples for n clock edges
  task automatic hold(input int n, input int a, input int b);
    chan_a_sample = spdenc_pkg::SW'(a);
    chan_b_sample = spdenc_pkg::SW'(b);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  // One target cycle; zero width means a swing below the operate point
  task automatic cycle(input int p, input logic bhi, input int us, input logic [1:0] ec);
    logic [15:0] n0;
    int          b;
    int          k;
    n0 = count_ff;
    b = bhi ? 500 : -500;
    k = 0;
    hold(p / 4, -500, b);
    hold(p / 2, (us == 0) ? 200 : 500, b);
    hold(p / 4, -500, b);
    while (current_high_ff !== 1'b0 && k < 5000) begin
      hold(1, -500, b);
      k++;
    end
    hold(2, -500, b);
    chk(count_ff, n0 + 16'((us != 0) ? 1 : 0));
    if (us != 0) begin
      chk(width_ff, 16'(us * spdenc_pkg::CYC_PER_US));
      chk(16'(class_ff), 16'(ec));
      chk(16'(direction_code_ff), 16'(ec));
    end
  endtask
  task automatic t_inter();
    chk(16'(direction_code_ff), 16'(U));
    repeat (4) cycle(3000, 1'b1, 30, U);
    cycle(3000, 1'b1, 60, F);
    cycle(3000, 1'b0, 30, U);
    cycle(3000, 1'b0, 120, R);
  endtask
  task automatic t_hs();
    cycle(3000, 1'b1, 30, U);
    cycle(3000, 1'b1, 60, F);
    cycle(1000, 1'b1, 60, F);
    cycle(1000, 1'b1, 60, F);
    chk(16'(high_speed_ff), 16'h1);
    cycle(1000, 1'b1, 30, U);
    cycle(1000, 1'b0, 30, U);
    cycle(5800, 1'b0, 30, U);
    chk(16'(high_speed_ff), 16'h1);
    cycle(3000, 1'b0, 30, U);
    chk(16'(high_speed_ff), 16'h0);
    cycle(3000, 1'b0, 120, R);
  endtask
  task automatic t_opts();
    width_option = spdenc_pkg::OPT_NARROW;
    cycle(4000, 1'b0, 90, R);
    cycle(4000, 1'b1, 180, U);
    cycle(4000, 1'b1, 45, F);
    cycle(4000, 1'b1, 0, F);
    reversed_orientation = 1'b1;
    cycle(4000, 1'b0, 45, F);
    width_option = spdenc_pkg::OPT_WIDE;
    cycle(4000, 1'b0, 45, F);
    cycle(4000, 1'b1, 360, U);
    cycle(4000, 1'b1, 180, R);
  endtask
  task automatic t_timeout();
    chk(16'(calibrated_ff), 16'h1);
    timed_reset_enable = 1'b1;
    hold(TMO_CYC + 100, -500, 500);
    chk(16'(calibrated_ff), 16'h0);
    cycle(4000, 1'b1, 360, U);
  endtask
  // Crossing inside a pulse is dropped; the next follows a short low gap
  task automatic t_rate();
    logic [15:0] n0;
    n0 = count_ff;
    width_option = spdenc_pkg::OPT_NARROW;
    hold(250, 500, 500);
    hold(250, -500, 500);
    hold(250, 500, 500);
    hold(1400, -500, 500);
    hold(250, 500, 500);
    hold(2000, -500, 500);
    chk(count_ff, n0 + 16'h2);
    chk(width_ff, 16'(spdenc_pkg::NARROW_UNK_US * spdenc_pkg::CYC_PER_US));
    chk(16'(class_ff), 16'(U));
  endtask
  initial begin
    ref_clk = 1'b0;
    rst_n = 1'b0;
    width_option = spdenc_pkg::OPT_INTER;
    reversed_orientation = 1'b0;
    timed_reset_enable = 1'b0;
    chan_a_sample = '0;
    chan_b_sample = '0;
    failures = 0;
    num_checks = 0;
    cycles = 0;
    repeat (2) @(posedge ref_clk);
    #1;
    rst_n = 1'b1;
    t_inter();
    t_hs();
    t_opts();
    t_timeout();
    t_rate();
    print_verdict();
  end
endmodule
`default_nettype wire
